// [cell_cluster.sv]
// Purpose: ten-cell cluster with cascade chain and counter mode
// Assumes: Avalon-MM slave, one wait state on every access
// Notes:   cluster clear and controls are synchronous to ref_clk
`timescale 1ns/1ps
module cell_cluster
	import cluster_pkg::*;
(
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	// register bus
	input  wire logic [AW-1:0]             address,
	input  wire logic                      read,
	input  wire logic                      write,
	input  wire logic [31:0]               writedata,
	input  wire logic [3:0]                byteenable,
	output logic [31:0]                    readdata,
	output logic                           waitrequest,
	// cell inputs from local interconnect
	input  wire logic [N_CELLS*N_IN-1:0]   cell_in,
	// global controls
	input  wire logic                      glb_clr,
	input  wire logic                      glb_sclr,
	input  wire logic                      glb_sload,
	input  wire logic                      glb_cnt,
	// cascade links to clusters two positions away
	input  wire logic                      casc_link_in,
	output logic                           casc_link_out,
	// two local interconnect groups
	output logic [N_CELLS-1:0]             loc_grp_a,
	output logic [N_CELLS-1:0]             loc_grp_b,
	// counter word
	output logic [CNT_W-1:0]               count_word
);

	// configuration and bus response state
	logic [31:0]          ctrl_r;
	logic [31:0]          casc_r;
	logic [TABLE_W-1:0]   table_r [N_CELLS];
	logic                 ack_r;
	logic [31:0]          rdata_r;

	// cell wiring
	logic [N_CELLS-1:0]   casc_o;
	logic [N_CELLS-1:0]   casc_i;
	logic [N_CELLS-1:0]   carry_o;
	logic [N_CELLS-1:0]   carry_i;
	logic [N_CELLS-1:0]   q;
	logic [N_CELLS-1:0]   join_en;
	logic [N_CELLS-1:0]   reg_end;
	logic [N_CELLS-1:0]   cell_out;
	logic [N_CELLS-1:0]   cnt_en_vec;
	logic [N_IN-1:0]      ctl_in;

	// cluster controls after selection, and bus decode signals
	logic                 cl_clr;
	logic                 cl_sclr;
	logic                 cl_sload;
	logic                 cl_cnt;
	logic                 cnt_go;
	logic                 cnt_up;
	logic                 local_ctl;
	logic                 casc_or;
	logic                 cnt_mode;
	logic [COL_W-1:0]     col;
	logic                 link_in_ok;
	logic                 req;
	logic                 hit_table;
	logic [3:0]           tbl_idx;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				res[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return res;
	endfunction : merge_bytes

	assign local_ctl = ctrl_r[CTRL_LOCAL];
	assign casc_or   = ctrl_r[CTRL_CASC_OR];
	assign cnt_mode  = ctrl_r[CTRL_CNT_MODE];
	assign col       = ctrl_r[CTRL_COL_LSB +: COL_W];

	// bus decode
	assign req       = read | write;
	assign tbl_idx   = 4'((address - OFS_TABLE0) >> 2);
	assign hit_table = (address >= OFS_TABLE0)
		&& (address < 8'(OFS_TABLE0 + 8'(N_CELLS * 4)))
		&& (address[1:0] == 2'b00);

	// one wait state: answer at the second edge of every request
	assign waitrequest = req & ~ack_r;
	assign readdata    = rdata_r;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= 32'h0000_0000;
		else if (read && !ack_r)
		begin
			rdata_r <= 32'h0000_0000;
			if (address == OFS_CTRL)
				rdata_r <= ctrl_r;
			else if (address == OFS_CASC)
				rdata_r <= casc_r;
			else if (address == OFS_STATUS)
			begin
				rdata_r[STAT_Q_LSB +: N_CELLS]    <= q;
				rdata_r[STAT_COMB_LSB +: N_CELLS] <= cell_out;
			end
			else if (hit_table)
				rdata_r[TABLE_W-1:0] <= table_r[tbl_idx];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= CTRL_RST;
		else if (write && ack_r && address == OFS_CTRL)
			ctrl_r <= merge_bytes(ctrl_r, writedata, byteenable);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			casc_r <= CASC_RST;
		else if (write && ack_r && address == OFS_CASC)
			casc_r <= merge_bytes(casc_r, writedata, byteenable);
	end

	// ten function tables, one per cell
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < N_CELLS; i++)
				table_r[i] <= TABLE_RST;
		end
		else if (write && ack_r && hit_table)
			table_r[tbl_idx] <= TABLE_W'(merge_bytes(32'(table_r[tbl_idx]),
				writedata, byteenable));
	end

	// cell 0 inputs become the cluster controls when local mode is on
	assign ctl_in   = cell_in[0 +: N_IN];
	assign cl_clr   = local_ctl ? ctl_in[0] : glb_clr;
	assign cl_sclr  = local_ctl ? ctl_in[1] : glb_sclr;
	assign cl_sload = local_ctl ? ctl_in[2] : glb_sload;
	assign cl_cnt   = local_ctl ? ctl_in[3] : glb_cnt;

	// one control line serves either as enable or as direction
	assign cnt_go = ctrl_r[CTRL_UPDOWN] ? 1'b1 : cl_cnt;
	assign cnt_up = ctrl_r[CTRL_UPDOWN] ? cl_cnt : 1'b1;

	// cell 0 may be busy making controls, so it never cascades
	assign join_en = {casc_r[CASC_JOIN_LSB+1 +: N_CELLS-1], 1'b0};

	// a link arriving at the first cluster past the centre is ignored
	assign link_in_ok = ctrl_r[CTRL_CASC_IN] && (col != COL_FIRST);

	// a linked chain enters at cell 1, skipping cell 0
	assign casc_i[0] = 1'b0;
	// an unlinked chain starts from its gate's identity: one for an and chain, zero for an or chain
	assign casc_i[1] = link_in_ok ? casc_link_in : ~casc_or;
	generate
		for (genvar g = 2; g < N_CELLS; g++)
		begin : g_casc
			assign casc_i[g] = casc_o[g-1];
		end
	endgenerate

	// only the last cell may register the chain
	assign reg_end = {casc_r[CASC_REG_END], {(N_CELLS-1){1'b0}}};

	// counter runs from cell 1 upward; cell 1 toggles when cnt_go is high and no clear or load is active
	assign carry_i[0] = 1'b0;
	assign carry_i[1] = cnt_go;
	generate
		for (genvar g = 2; g < N_CELLS; g++)
		begin : g_carry
			assign carry_i[g] = carry_o[g-1];
		end
	endgenerate

	assign cnt_en_vec = {{(N_CELLS-1){cnt_mode}}, 1'b0};

	generate
		for (genvar g = 0; g < N_CELLS; g++)
		begin : g_cell
			logic [N_IN-1:0] cin;
			// cell 0 inputs are taken over by the controls in local mode
			assign cin = (g == 0 && local_ctl) ? '0 : cell_in[g*N_IN +: N_IN];
			logic_cell u_cell (
				.ref_clk   (ref_clk),
				.rst_n     (rst_n),
				.table_cfg (table_r[g]),
				.casc_join (join_en[g]),
				.casc_or   (casc_or),
				.reg_casc  (reg_end[g]),
				.din       (cin),
				.casc_in   (casc_i[g]),
				.casc_out  (casc_o[g]),
				.table_out (),
				.cnt_mode  (cnt_en_vec[g]),
				.carry_in  (carry_i[g]),
				.count_up  (cnt_up),
				.carry_out (carry_o[g]),
				.aclr      (cl_clr),
				.sclr      (cl_sclr),
				.sload     (cl_sload),
				.ld_hold   (ctrl_r[CTRL_LD_HOLD]),
				.q_r       (q[g])
			);
			assign cell_out[g] = casc_r[CASC_USE_LSB + g] ? q[g] : casc_o[g];
		end
	endgenerate

	// registered drive into both neighbour interconnect groups
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loc_grp_a <= '0;
			loc_grp_b <= '0;
		end
		else
		begin
			loc_grp_a <= cell_out;
			loc_grp_b <= cell_out;
		end
	end

	// chain continues two clusters on, but never past the row centre
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			casc_link_out <= 1'b0;
		else if (col == COL_LAST)
			casc_link_out <= 1'b0;
		else
			casc_link_out <= casc_o[N_CELLS-1];
	end

	assign count_word = q[N_CELLS-1:1];

endmodule : cell_cluster

// [cluster_pkg.sv]
// Purpose: shared constants for one ten-cell logic cluster
// Assumes: 32-bit Avalon-MM register port, byte addresses
// Notes:   table registers are one word per cell, low 16 bits
package cluster_pkg;

	localparam int N_CELLS   = 10;
	localparam int N_IN      = 4;
	localparam int TABLE_W   = 16;
	localparam int AW        = 8;

	// register byte offsets
	localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
	localparam logic [AW-1:0] OFS_CASC   = 8'h04;
	localparam logic [AW-1:0] OFS_STATUS = 8'h08;
	localparam logic [AW-1:0] OFS_TABLE0 = 8'h10;

	// control register fields
	localparam int CTRL_CNT_MODE = 0;
	localparam int CTRL_UPDOWN   = 1;
	localparam int CTRL_CASC_OR  = 2;
	localparam int CTRL_LOCAL    = 3;
	localparam int CTRL_LD_HOLD  = 4;
	localparam int CTRL_CASC_IN  = 5;
	localparam int CTRL_COL_LSB  = 8;
	localparam int COL_W         = 8;

	// cascade register fields
	localparam int CASC_JOIN_LSB = 0;
	localparam int CASC_REG_END  = 10;
	localparam int CASC_USE_LSB  = 16;

	// status register fields
	localparam int STAT_Q_LSB    = 0;
	localparam int STAT_COMB_LSB = 16;

	// row position of the chain break, 1-based cluster numbers
	localparam logic [COL_W-1:0] COL_LAST  = 8'h0B;
	localparam logic [COL_W-1:0] COL_FIRST = 8'h0C;

	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] CASC_RST  = 32'h0000_0000;
	localparam logic [TABLE_W-1:0] TABLE_RST = 16'h0000;

	localparam int CNT_W = N_CELLS - 1;

endpackage : cluster_pkg

// [logic_cell.sv]
// Purpose: one logic cell: function table, cascade gate, register
// Assumes: all controls synchronous to ref_clk
// Notes:   count mode overrides the table path into the register
`timescale 1ns/1ps
module logic_cell
	import cluster_pkg::*;
(
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// configuration
	input  wire logic [TABLE_W-1:0] table_cfg,
	input  wire logic               casc_join,
	input  wire logic               casc_or,
	input  wire logic               reg_casc,
	// data
	input  wire logic [N_IN-1:0]    din,
	input  wire logic               casc_in,
	output logic                    casc_out,
	output logic                    table_out,
	// counter
	input  wire logic               cnt_mode,
	input  wire logic               carry_in,
	input  wire logic               count_up,
	output logic                    carry_out,
	// register controls
	input  wire logic               aclr,
	input  wire logic               sclr,
	input  wire logic               sload,
	input  wire logic               ld_hold,
	output logic                    q_r
);

	logic d_nxt;

	assign table_out = table_cfg[din];

	// or form by inverting both inputs and the output of the and gate
	always_comb
	begin
		if (!casc_join)
			casc_out = table_out;
		else if (casc_or)
			casc_out = ~(~table_out & ~casc_in);
		else
			casc_out = table_out & casc_in;
	end

	// only an and chain can be registered; an or chain leaves the table output in the register
	assign d_nxt = (reg_casc && !casc_or) ? casc_out : table_out;

	assign carry_out = count_up ? (q_r & carry_in) : (~q_r & carry_in);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			q_r <= 1'b0;
		else if (aclr)
			q_r <= 1'b0;
		else if (sclr)
			q_r <= 1'b0;
		else if (sload)
			q_r <= ld_hold ? q_r : din[0];
		else if (cnt_mode)
			q_r <= q_r ^ carry_in;
		else
			q_r <= d_nxt;
	end

endmodule : logic_cell

// [neighbour_cluster.sv]
// Purpose: cluster two places back on the cascade link
// Assumes: bench sets this cluster's chain value
// Notes:   link is registered, like the block's own link
`timescale 1ns/1ps
module neighbour_cluster
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// chain
	input  wire logic chain_val,
	output logic      link_out
);
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			link_out <= 1'b0;
		else
			link_out <= chain_val;
endmodule : neighbour_cluster

// [cell_cluster_checker.sv]
// Purpose: port assertions for cell_cluster
// Assumes: control word shadowed from full-word bus writes
// Notes:   local control mode is left to the bench
`timescale 1ns/1ps
module cell_cluster_checker
	import cluster_pkg::*;
(
	// clock, reset, bus
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	input wire logic [AW-1:0]           address,
	input wire logic                    read,
	input wire logic                    write,
	input wire logic [31:0]             writedata,
	input wire logic [31:0]             readdata,
	input wire logic                    waitrequest,
	// cells and controls
	input wire logic [N_CELLS*N_IN-1:0] cell_in,
	input wire logic                    glb_clr,
	input wire logic                    glb_sclr,
	input wire logic                    glb_sload,
	input wire logic                    glb_cnt,
	// outputs
	input wire logic                    casc_link_out,
	input wire logic [N_CELLS-1:0]      loc_grp_a,
	input wire logic [N_CELLS-1:0]      loc_grp_b,
	input wire logic [CNT_W-1:0]        count_word
);
	logic [15:0]      ctrl_r;
	logic [CNT_W-1:0] din0;
	logic             cm;
	logic             quiet;
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			ctrl_r <= 16'h0000;
		else if (write && !waitrequest && address == OFS_CTRL)
			ctrl_r <= writedata[15:0];
	always_comb
		for (int g = 1; g < N_CELLS; g++)
			din0[g-1] = cell_in[N_IN*g];
	assign cm = ctrl_r[CTRL_CNT_MODE] && !ctrl_r[CTRL_LOCAL];
	assign quiet = cm && !glb_clr && !glb_sclr && !glb_sload;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wait_one_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("bus wait state wrong");
	unmapped_a: assert property (read && !waitrequest && address > 8'h34 |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	grp_copy_a: assert property (loc_grp_a == loc_grp_b)
		else $error("local groups differ");
	count_up_a: assert property (quiet && glb_cnt |=> count_word == $past(count_word) + 9'h001)
		else $error("count up step wrong");
	count_down_a: assert property (quiet && ctrl_r[CTRL_UPDOWN] && !glb_cnt |=> count_word == $past(count_word) - 9'h001)
		else $error("count down step wrong");
	sync_clear_a: assert property (!ctrl_r[CTRL_LOCAL] && (glb_clr || glb_sclr) |=> count_word == 9'h000)
		else $error("clear missed");
	sync_load_a: assert property (cm && glb_sload && !glb_clr && !glb_sclr && !ctrl_r[CTRL_LD_HOLD] |=> count_word == $past(din0))
		else $error("load value wrong");
	load_hold_a: assert property (cm && glb_sload && !glb_clr && !glb_sclr && ctrl_r[CTRL_LD_HOLD] |=> $stable(count_word))
		else $error("held count moved");
	row_end_a: assert property (ctrl_r[15:8] == COL_LAST |=> !casc_link_out)
		else $error("link crossed row centre");
endmodule : cell_cluster_checker
bind cell_cluster cell_cluster_checker cell_cluster_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .cell_in(cell_in),
	.glb_clr(glb_clr), .glb_sclr(glb_sclr), .glb_sload(glb_sload), .glb_cnt(glb_cnt),
	.casc_link_out(casc_link_out), .loc_grp_a(loc_grp_a), .loc_grp_b(loc_grp_b),
	.count_word(count_word));

// [cell_cluster_test.sv]
// Purpose: self-checking bench for cell_cluster
// Assumes: every bus access answered after one wait state
// Notes:   expected values come from a table model here
`timescale 1ns/1ps
module cell_cluster_test
	import cluster_pkg::*;
;
	logic                    ref_clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic [AW-1:0]           address = 8'h00;
	logic                    read = 1'b0;
	logic                    write = 1'b0;
	logic [31:0]             writedata = 32'h0;
	logic [N_CELLS*N_IN-1:0] cell_in = 40'h0;
	logic [3:0]              glb = 4'h0;
	logic                    nb_chain = 1'b0;
	logic                    nb_link;
	logic [31:0]             readdata;
	logic                    waitrequest;
	logic                    casc_link_out;
	logic [N_CELLS-1:0]      loc_grp_a;
	logic [CNT_W-1:0]        count_word;
	logic [15:0]             tbl[N_CELLS];
	logic [31:0]             cs_tab[3] = '{32'h0, 32'h3FF, 32'h3FA};
	logic [7:0]              cols[3] = '{8'h03, COL_LAST, COL_FIRST};
	logic [31:0]             q;
	logic [CNT_W-1:0]        e;
	logic                    ch;
	int                      n_errors = 0;
	int                      n_compared = 0;
	int                      seed = 87;
	int                      cnt;
	int                      k;
	initial
		forever #5 ref_clk = ~ref_clk;
	cell_cluster cell_cluster_i (.ref_clk(ref_clk), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
		.readdata(readdata), .waitrequest(waitrequest), .cell_in(cell_in),
		.glb_clr(glb[0]), .glb_sclr(glb[1]), .glb_sload(glb[2]), .glb_cnt(glb[3]),
		.casc_link_in(nb_link), .casc_link_out(casc_link_out), .loc_grp_a(loc_grp_a),
		.loc_grp_b(), .count_word(count_word));
	neighbour_cluster neighbour_cluster_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.chain_val(nb_chain), .link_out(nb_link));
	task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] s);
		n_compared++;
		if (s !== x)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask : cmp
	task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		// read just after the edge, so these are the values the slave sampled
		do
			@(posedge ref_clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic drive(input int b, input logic v, input int n);
		@(posedge ref_clk);
		glb[b] <= v;
		repeat (n) @(posedge ref_clk);
		glb[b] <= !v;
		@(negedge ref_clk);
	endtask : drive
	function automatic logic [9:0] model(input logic [31:0] cs, input logic om);
		logic [9:0] o;
		logic       p;
		logic       t;
		p = 1'b1;
		for (int g = 0; g < N_CELLS; g++)
		begin
			t = tbl[g][cell_in[N_IN*g +: N_IN]];
			o[g] = (g > 0 && cs[g]) ? (om ? p | t : p & t) : t;
			p = (g == 0) ? !om : o[g];
		end
		return o;
	endfunction : model
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		give_verdict();
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		bus(1, 8'h40, 32'hFFFF_FFFF);
		foreach (cols[i])
		begin
			bus(0, (i == 2) ? 8'h40 : AW'(4*i), 32'h0);
			cmp("reset", CTRL_RST, q);
		end
		for (int g = 0; g < N_CELLS; g++)
		begin
			tbl[g] = 16'($random(seed));
			bus(1, OFS_TABLE0 + AW'(4*g), {16'h0, tbl[g]});
			bus(0, OFS_TABLE0 + AW'(4*g), 32'h0);
			cmp("table", {16'h0, tbl[g]}, q);
		end
		for (int m = 0; m < 3; m++)
		begin
			bus(1, OFS_CTRL, 32'(m == 2) << CTRL_CASC_OR);
			bus(1, OFS_CASC, cs_tab[m]);
			repeat (6)
			begin
				@(posedge ref_clk);
				cell_in <= 40'({$random(seed), $random(seed)});
				bus(0, OFS_STATUS, 32'h0);
				cmp("comb", model(cs_tab[m], m == 2), q[25:16]);
				cmp("group", model(cs_tab[m], m == 2), loc_grp_a);
			end
		end
		// all-ones tables make the chain show the link; cell 9 cleared for OR
		for (int g = 0; g < N_CELLS; g++)
			bus(1, OFS_TABLE0 + AW'(4*g), 32'hFFFF);
		bus(1, OFS_CASC, 32'h7FE);
		for (int i = 0; i < 12; i++)
		begin
			if (i == 6)
				bus(1, OFS_TABLE0 + 8'h24, 32'h0);
			bus(1, OFS_CTRL, {16'h0, cols[i%3], 8'h20} | (32'(i / 6) << CTRL_CASC_OR));
			nb_chain <= 1'((i / 3) % 2);
			repeat (3) @(posedge ref_clk);
			bus(0, OFS_STATUS, 32'h0);
			ch = i >= 6 || cols[i%3] == COL_FIRST || (i / 3) % 2;
			cmp("chain", ch, q[25]);
			cmp("end reg", (i < 6) && ch, q[9]);
			cmp("link", ch && cols[i%3] != COL_LAST, casc_link_out);
		end
		bus(1, OFS_CTRL, 32'h11);
		drive(0, 1'b1, 1);
		cnt = 0;
		cmp("clear", cnt, count_word);
		k = 1 + $unsigned($random(seed)) % 30;
		drive(3, 1'b1, k);
		cnt += k;
		cmp("up", cnt, count_word);
		@(posedge ref_clk);
		glb[2] <= 1'b1;
		bus(1, OFS_CTRL, 32'h13);
		drive(2, 1'b0, k + 3);
		cnt -= k + 3;
		cmp("down", cnt & 511, count_word);
		@(posedge ref_clk);
		glb[3] <= 1'b1;
		drive(2, 1'b0, 2);
		cnt += 2;
		cmp("hold up", cnt & 511, count_word);
		@(posedge ref_clk);
		glb[3] <= 1'b0;
		cell_in <= 40'({$random(seed), $random(seed)});
		bus(1, OFS_CTRL, 32'h1);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		for (int g = 1; g < N_CELLS; g++)
			e[g-1] = cell_in[N_IN*g];
		cmp("load", e, count_word);
		drive(1, 1'b1, 1);
		cmp("sclr", 32'h0, count_word);
		@(posedge ref_clk);
		glb[2] <= 1'b0;
		cell_in <= 40'h0;
		bus(1, OFS_CTRL, 32'h9);
		@(posedge ref_clk);
		cell_in <= 40'h1;
		@(posedge ref_clk);
		cell_in <= 40'h8;
		repeat (k) @(posedge ref_clk);
		cell_in <= 40'h0;
		@(negedge ref_clk);
		cmp("local", k, count_word);
		give_verdict();
	end
endmodule : cell_cluster_test
